// File: pkg/sideband_pkg.sv
// Constants, types and timing shared by the SATA sideband block.
// Assumes a single core clock at CORE_CLK_HZ and no software registers.
//
// Functional notes
// R1: An interlock pin is held low for a closed switch, high for an open one.
// R2: Shared port pins leave reset as GPIO; combo select needs its strap.
// R3: The LED pin is pulled low while any command is active, else released.
// R4: Driven low means LED on, released means LED off, no third state.
// R5: Serial data and load change only on rising serial clock edges.
// R6: The target samples data and load on the falling serial clock edge.
// R7: The serial clock runs at 32 kHz and at no other rate.
// R8: Load goes high on a rising clock edge to mark each frame boundary.
// R9: A 4-bit vendor pattern follows on the load line right after it.
// R10: Each data line sends drives 0 to 7 in order each frame, then repeats.
// R11: With the serial link off its four pins act as ordinary GPIO pins.
// R12: With flex strap 11 the lane follows the select pin and polarity strap.
// R13: Load is low outside boundary and pattern bits; data runs while enabled.
package sideband_pkg;

  // Timing
  localparam int unsigned CORE_CLK_HZ   = 40_000_000;
  localparam int unsigned SCLK_HZ       = 32_000;
  localparam int unsigned SCLK_HALF_CYC = CORE_CLK_HZ / (2 * SCLK_HZ);
  localparam int unsigned DIV_W         = 10;
  localparam logic [DIV_W-1:0] SCLK_HALF_LAST = DIV_W'(SCLK_HALF_CYC - 1);

  // Frame layout
  localparam int unsigned DRIVES     = 8;
  localparam int unsigned BIT_W      = 3;
  localparam logic [BIT_W-1:0] BIT_FIRST  = 3'h0;
  localparam logic [BIT_W-1:0] BIT_LAST   = 3'h7;
  localparam logic [BIT_W-1:0] PAT_FIRST  = 3'h1;
  localparam logic [BIT_W-1:0] PAT_LAST   = 3'h4;
  localparam int unsigned PAT_W      = 4;
  localparam int unsigned WORD_W     = 2 * DRIVES;

  // Serial pin indices
  localparam int unsigned PIN_SCLK  = 0;
  localparam int unsigned PIN_LOAD  = 1;
  localparam int unsigned PIN_DATA0 = 2;
  localparam int unsigned PIN_DATA1 = 3;
  localparam int unsigned SG_PINS   = 4;

  // Strap codes
  localparam logic [1:0] FLEX_BY_PIN = 2'h3;
  localparam logic [1:0] FLEX_SATA   = 2'h1;

  typedef enum logic [1:0] {
    SG_IDLE = 2'b01,
    SG_RUN  = 2'b10
  } sgpio_state_type;

  typedef enum logic [2:0] {
    PM_GPIO      = 3'b001,
    PM_INTERLOCK = 3'b010,
    PM_COMBO     = 3'b100
  } port_mode_type;

endpackage

// File: rtl/stream_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module stream_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("stream_fifo DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outValid = count_reg != '0;
  assign outData  = mem[rdPtr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  // Storage
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers and level
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      inReady   <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + AW'(1);
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + AW'(1);
      end
      count_reg <= count_next;
      inReady   <= count_next != (AW+1)'(DEPTH);
    end
  end

endmodule

// File: rtl/sata_sideband_sgpio.sv
// Sideband logic of a multi-port SATA controller: interlock and combo
// select pins, open-drain activity LED and the serial drive status link.
// Assumes pin inputs are asynchronous; straps and command activity
// come from logic on core_clk. Pads resolve open-drain from the enables.
`timescale 1ns/1ps
module sata_sideband_sgpio
  import sideband_pkg::*;
#(
  parameter int unsigned PORTS      = 8,
  parameter int unsigned FIFO_DEPTH = 32,
  parameter logic [PAT_W-1:0] VENDOR_PATTERN = 4'h0
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  // Shared port pins and their straps
  input  wire logic [PORTS-1:0]     portInterlockIn,
  input  wire logic [PORTS-1:0]     interlockEnable,
  input  wire logic [2*PORTS-1:0]   comboFlexStrap,
  input  wire logic [PORTS-1:0]     comboPolarityStrap,
  output logic      [PORTS-1:0]     switchClosed,
  output logic      [PORTS-1:0]     laneIsSata,
  output logic      [PORTS-1:0]     gpioPortLevel,
  // Activity LED, open drain
  input  wire logic [PORTS-1:0]     cmdActive,
  output logic                      activityLedNOut,
  output logic                      activityLedNOe,
  // Serial link control and status words
  input  wire logic                 sgpioEnable,
  input  wire logic [SG_PINS-1:0]   gpioDriveLow,
  input  wire logic                 statusValid,
  input  wire logic [WORD_W-1:0]    statusData,
  output logic                      statusReady,
  // Serial link pins, open drain: clock, load, data0, data1
  output logic      [SG_PINS-1:0]   sgpioPinOut,
  output logic      [SG_PINS-1:0]   sgpioPinOe
);

  if (PORTS < 1 || PORTS > DRIVES) begin : g_chk
    $error("sata_sideband_sgpio PORTS must lie in 1..8");
  end

  // Lane type chosen by straps and the sampled select pin
  function automatic logic laneSata(input logic [1:0] flex,
                                    input logic       pol,
                                    input logic       pin);
    if (flex == FLEX_BY_PIN) begin
      laneSata = (pin != pol);
    end else begin
      laneSata = (flex == FLEX_SATA);
    end
  endfunction

  // ---------------------------------------------------------------
  // Port pins
  // ---------------------------------------------------------------
  logic [PORTS-1:0]   pinMeta_reg;
  logic [PORTS-1:0]   pinSync_reg;
  logic               strapTaken_reg;
  logic [2*PORTS-1:0] flex_reg;
  logic [PORTS-1:0]   pol_reg;
  port_mode_type      portMode_reg [PORTS];

  // Two-stage synchroniser for the port pins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pinMeta_reg <= '1;
      pinSync_reg <= '1;
    end else begin
      pinMeta_reg <= portInterlockIn;
      pinSync_reg <= pinMeta_reg;
    end
  end

  // Straps are caught at the first edge after reset release
  always_ff @(posedge core_clk) begin
    if (srst) begin
      strapTaken_reg <= 1'b0;
      flex_reg       <= '0;
      pol_reg        <= '0;
    end else if (!strapTaken_reg) begin
      strapTaken_reg <= 1'b1;
      flex_reg       <= comboFlexStrap;
      pol_reg        <= comboPolarityStrap;
    end
  end

  // Pin function per port
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < PORTS; i++) begin
      if (srst || !strapTaken_reg) begin
        portMode_reg[i] <= PM_GPIO; // see R2
      end else if (flex_reg[2*i +: 2] == FLEX_BY_PIN) begin
        portMode_reg[i] <= PM_COMBO; // see R2
      end else if (interlockEnable[i]) begin
        portMode_reg[i] <= PM_INTERLOCK;
      end else begin
        portMode_reg[i] <= PM_GPIO;
      end
    end
  end

  // Per-port results
  always_ff @(posedge core_clk) begin
    if (srst) begin
      switchClosed  <= '0;
      laneIsSata    <= '0;
      gpioPortLevel <= '0;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        // Low level means switch closed
        switchClosed[i] <= (portMode_reg[i] == PM_INTERLOCK)
                           && !pinSync_reg[i]; // see R1
        gpioPortLevel[i] <= (portMode_reg[i] == PM_GPIO)
                            && pinSync_reg[i];
        laneIsSata[i] <= laneSata(flex_reg[2*i +: 2], pol_reg[i],
                                  pinSync_reg[i]); // see R12
      end
    end
  end

  // ---------------------------------------------------------------
  // Activity LED
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      activityLedNOut <= 1'b0;
      activityLedNOe  <= 1'b0;
    end else begin
      activityLedNOut <= 1'b0; // see R4
      activityLedNOe  <= |cmdActive; // see R3
    end
  end

  // ---------------------------------------------------------------
  // Status word FIFO
  // ---------------------------------------------------------------
  logic              fifoOutValid;
  logic [WORD_W-1:0] fifoOutData;
  logic              fifoOutReady;

  stream_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .srst     (srst),
    .inValid  (statusValid),
    .inData   (statusData),
    .inReady  (statusReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (fifoOutReady)
  );

  // ---------------------------------------------------------------
  // Serial link
  // ---------------------------------------------------------------
  sgpio_state_type   state_reg;
  sgpio_state_type   state_next;
  logic [DIV_W-1:0]  div_reg;
  logic [DIV_W-1:0]  div_next;
  logic              sclk_reg;
  logic              sclk_next;
  logic [BIT_W-1:0]  bit_reg;
  logic [BIT_W-1:0]  bit_next;
  logic [WORD_W-1:0] word_reg;
  logic [WORD_W-1:0] word_next;
  logic              load_reg;
  logic              load_next;
  logic              data0_reg;
  logic              data0_next;
  logic              data1_reg;
  logic              data1_next;
  logic              riseTick;
  logic              halfDone;
  logic [BIT_W-1:0]  patIdx;

  assign halfDone = (state_reg == SG_RUN) && (div_reg == SCLK_HALF_LAST);
  assign riseTick = halfDone && !sclk_reg;
  assign patIdx   = bit_next - PAT_FIRST;
  // Take a fresh word at each frame start when one waits
  assign fifoOutReady = riseTick && (bit_next == BIT_FIRST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SG_IDLE: begin
        if (sgpioEnable) begin
          state_next = SG_RUN;
        end
      end
      SG_RUN: begin
        if (!sgpioEnable) begin
          state_next = SG_IDLE;
        end
      end
      default: begin
        state_next = SG_IDLE;
      end
    endcase
  end

  // Divider and bit counter
  always_comb begin
    div_next  = div_reg;
    sclk_next = sclk_reg;
    bit_next  = bit_reg;
    if (state_reg != SG_RUN) begin
      div_next  = '0;
      sclk_next = 1'b0;
      bit_next  = BIT_LAST;
    end else if (halfDone) begin
      div_next  = '0;
      sclk_next = !sclk_reg; // see R7
      if (!sclk_reg) begin
        bit_next = (bit_reg == BIT_LAST) ? BIT_FIRST
                                         : bit_reg + BIT_W'(1); // see R10
      end
    end else begin
      div_next = div_reg + DIV_W'(1);
    end
  end

  // Load and data: cleared while the link is not running, else updated only on the rising clock tick
  always_comb begin
    word_next  = word_reg;
    load_next  = load_reg;
    data0_next = data0_reg;
    data1_next = data1_reg;
    if (state_reg != SG_RUN) begin
      load_next  = 1'b0;
      data0_next = 1'b0;
      data1_next = 1'b0;
    end else if (riseTick) begin // see R5
      if (bit_next == BIT_FIRST && fifoOutValid) begin
        word_next = fifoOutData;
      end
      if (bit_next == BIT_FIRST) begin
        load_next = 1'b1; // see R8
      end else if (bit_next >= PAT_FIRST && bit_next <= PAT_LAST) begin
        load_next = VENDOR_PATTERN[PAT_W - 1 - int'(patIdx)]; // see R9
      end else begin
        load_next = 1'b0; // see R13
      end
      data0_next = word_next[bit_next]; // see R10
      data1_next = word_next[DRIVES + int'(bit_next)]; // see R10
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= SG_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_reg  <= '0;
      sclk_reg <= 1'b0;
      bit_reg  <= BIT_LAST;
    end else begin
      div_reg  <= div_next;
      sclk_reg <= sclk_next;
      bit_reg  <= bit_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      word_reg  <= '0;
      load_reg  <= 1'b0;
      data0_reg <= 1'b0;
      data1_reg <= 1'b0;
    end else begin
      word_reg  <= word_next;
      load_reg  <= load_next;
      data0_reg <= data0_next;
      data1_reg <= data1_next;
    end
  end

  // Open-drain pads: enable pulls low; GPIO use when link is off
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sgpioPinOut <= '0;
      sgpioPinOe  <= '0;
    end else begin
      sgpioPinOut <= '0;
      if (state_next == SG_RUN) begin
        sgpioPinOe[PIN_SCLK]  <= !sclk_next; // see R5
        sgpioPinOe[PIN_LOAD]  <= !load_next; // see R13
        sgpioPinOe[PIN_DATA0] <= !data0_next;
        sgpioPinOe[PIN_DATA1] <= !data1_next;
      end else begin
        sgpioPinOe <= gpioDriveLow; // see R11
      end
    end
  end

endmodule

// File: tb/sideband_chk.sv
// Checker for the LED and serial link pads of the sideband block.
// Assumes a bind to the top module; sees its ports only.
`timescale 1ns/1ps
module sideband_chk
  import sideband_pkg::*;
#(
  parameter int unsigned      PORTS          = 8,
  parameter logic [PAT_W-1:0] VENDOR_PATTERN = 4'h0
) (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               srst,
  // Activity LED
  input wire logic [PORTS-1:0]   cmdActive,
  input wire logic               activityLedNOut,
  input wire logic               activityLedNOe,
  // Serial link
  input wire logic               sgpioEnable,
  input wire logic [SG_PINS-1:0] gpioDriveLow,
  input wire logic [SG_PINS-1:0] sgpioPinOut,
  input wire logic [SG_PINS-1:0] sgpioPinOe
);
  localparam int HALF = 625;
  logic        sclk;
  logic        load;
  logic        ranRise;
  logic [10:0] halfCnt;
  logic [2:0]  bitIdx;
  logic [7:0]  loadExp;
  assign sclk = !sgpioPinOe[0];
  assign load = !sgpioPinOe[1];
  assign loadExp = {3'h0, VENDOR_PATTERN[0], VENDOR_PATTERN[1],
                    VENDOR_PATTERN[2], VENDOR_PATTERN[3], 1'b1};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Set once the link has made a whole clock rise
  always_ff @(posedge core_clk) begin
    if (srst || !sgpioEnable) ranRise <= 1'b0;
    else if ($rose(sclk)) ranRise <= 1'b1;
  end
  // Cycles since the last clock edge
  always_ff @(posedge core_clk) begin
    if ($changed(sclk)) halfCnt <= 11'h001;
    else halfCnt <= halfCnt + 11'h001;
  end
  // Bit index of the next clock rise
  always_ff @(posedge core_clk) begin
    if (srst || !sgpioEnable) bitIdx <= 3'h0;
    else if ($rose(sclk)) bitIdx <= bitIdx + 3'h1;
  end
  sequence sclkRise;
    sgpioEnable && $rose(sclk);
  endsequence
  sequence padMove;
    sgpioEnable && ranRise && $changed(sgpioPinOe[3:1]);
  endsequence
  a_led_on: assert property (|cmdActive |=> activityLedNOe)
    else $error("LED not driven after activity");
  a_led_off: assert property (!(|cmdActive) |=> !activityLedNOe)
    else $error("LED driven without activity");
  a_pads_low: assert property (
    !activityLedNOut && sgpioPinOut == 4'h0)
    else $error("Open drain pad driven high");
  a_gpio_pads: assert property (!sgpioEnable ##1 !sgpioEnable
    |-> sgpioPinOe == $past(gpioDriveLow)) else $error("GPIO pads wrong");
  a_sclk_half: assert property (
    sgpioEnable && ranRise && $changed(sclk) |-> halfCnt == HALF)
    else $error("Serial half period wrong");
  a_sclk_max: assert property (
    sgpioEnable && ranRise |-> halfCnt <= HALF)
    else $error("Serial clock stalled");
  a_pad_rise: assert property (padMove |-> $rose(sclk))
    else $error("Load or data moved off a clock rise");
  a_load_bits: assert property (
    sclkRise |-> load == loadExp[bitIdx])
    else $error("Load bit wrong");
endmodule

bind sata_sideband_sgpio sideband_chk #(
  .PORTS(PORTS), .VENDOR_PATTERN(VENDOR_PATTERN)
) chk_u (
  .core_clk(core_clk), .srst(srst), .cmdActive(cmdActive),
  .activityLedNOut(activityLedNOut), .activityLedNOe(activityLedNOe),
  .sgpioEnable(sgpioEnable), .gpioDriveLow(gpioDriveLow),
  .sgpioPinOut(sgpioPinOut), .sgpioPinOe(sgpioPinOe)
);

// File: tb/sgpio_target_model.sv
// Far side: serial status receiver and drive interlock switches.
// Assumes pad levels with pull-ups resolved by the bench.
`timescale 1ns/1ps
module sgpio_target_model #(
  parameter logic [3:0] PATTERN = 4'h0
) (
  // Serial pad levels
  input  wire logic       sclkLvl,
  input  wire logic       loadLvl,
  input  wire logic       data0Lvl,
  input  wire logic       data1Lvl,
  // Switches, 1 = closed
  input  wire logic [7:0] closedSw,
  output logic      [7:0] portInterlockIn,
  // Last whole frame
  output logic      [7:0] rxWord0,
  output logic      [7:0] rxWord1,
  output int              frameCnt
);
  logic [7:0] loadHist = 8'h00;
  logic [7:0] sh0 = 8'h00;
  logic [7:0] sh1 = 8'h00;
  assign portInterlockIn = ~closedSw;
  initial frameCnt = 0;
  // Sample on the falling clock edge
  always @(negedge sclkLvl) begin
    loadHist = {loadHist[6:0], loadLvl};
    sh0 = {data0Lvl, sh0[7:1]};
    sh1 = {data1Lvl, sh1[7:1]};
    if (loadHist == {1'b1, PATTERN, 3'b000}) begin
      rxWord0 = sh0;
      rxWord1 = sh1;
      frameCnt++;
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the SATA sideband block.
// Assumes the target model on the serial pads and pull-ups on every pad.
`timescale 1ns/1ps
module tb_top;
  import sideband_pkg::*;
  localparam logic [3:0] PAT = 4'h5;
  logic        core_clk, srst, sgpioEnable, statusValid, statusReady;
  logic        activityLedNOut, activityLedNOe, ledLvl;
  logic [7:0]  portInterlockIn, interlockEnable, comboPolarityStrap;
  logic [7:0]  cmdActive, closedSw, switchClosed, laneIsSata;
  logic [7:0]  gpioPortLevel, rx0, rx1;
  logic [15:0] comboFlexStrap, statusData;
  logic [3:0]  gpioDriveLow, sgpioPinOut, sgpioPinOe, lvl;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          frames;

  assign lvl = ~sgpioPinOe | sgpioPinOut;
  assign ledLvl = ~activityLedNOe | activityLedNOut;

  sata_sideband_sgpio #(
    .PORTS(8), .FIFO_DEPTH(32), .VENDOR_PATTERN(PAT)
  ) dut_u (
    .core_clk(core_clk), .srst(srst), .portInterlockIn(portInterlockIn),
    .interlockEnable(interlockEnable), .comboFlexStrap(comboFlexStrap),
    .comboPolarityStrap(comboPolarityStrap), .switchClosed(switchClosed),
    .laneIsSata(laneIsSata), .gpioPortLevel(gpioPortLevel),
    .cmdActive(cmdActive), .activityLedNOut(activityLedNOut),
    .activityLedNOe(activityLedNOe), .sgpioEnable(sgpioEnable),
    .gpioDriveLow(gpioDriveLow), .statusValid(statusValid),
    .statusData(statusData), .statusReady(statusReady),
    .sgpioPinOut(sgpioPinOut), .sgpioPinOe(sgpioPinOe));
  sgpio_target_model #(.PATTERN(PAT)) far_u (
    .sclkLvl(lvl[0]), .loadLvl(lvl[1]), .data0Lvl(lvl[2]), .data1Lvl(lvl[3]),
    .closedSw(closedSw), .portInterlockIn(portInterlockIn),
    .rxWord0(rx0), .rxWord1(rx1), .frameCnt(frames));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [15:0] w(int i);
    return {8'(i) ^ 8'hC3, 8'(i) + 8'h11};
  endfunction

  task automatic wait_frame;
    int f;
    f = frames;
    for (int i = 0; i < 12000 && frames == f; i++) tick(1);
    cmp("frame count", 16'(f + 1), 16'(frames));
  endtask

  task automatic t_ports;
    cmp("laneIsSata", 16'h0004, {8'h00, laneIsSata});
    cmp("switchClosed", 16'h0020, {8'h00, switchClosed});
    cmp("gpioPortLevel", 16'h00D4, {8'h00, gpioPortLevel});
    closedSw = 8'h03;
    tick(4);
    cmp("switchClosed", 16'h0000, {8'h00, switchClosed});
    cmp("laneIsSata", 16'h0006, {8'h00, laneIsSata});
  endtask

  task automatic t_led;
    cmdActive = 8'h08;
    tick(1);
    cmp("led level", 16'h0000, {15'h0000, ledLvl});
    cmdActive = 8'h00;
    tick(1);
    cmp("led level", 16'h0001, {15'h0000, ledLvl});
  endtask

  task automatic t_gpio;
    gpioDriveLow = 4'hA;
    tick(2);
    cmp("pad levels", 16'h0005, {12'h000, lvl});
    gpioDriveLow = 4'h0;
    tick(2);
  endtask

  task automatic t_fill;
    int n;
    logic rdy;
    n = 0;
    statusValid = 1'b1;
    repeat (40) begin
      statusData = w(n);
      rdy = statusReady;
      tick(1);
      if (rdy) n++;
    end
    statusValid = 1'b0;
    cmp("words taken", 16'h0020, 16'(n));
    cmp("ready when full", 16'h0000, {15'h0000, statusReady});
  endtask

  task automatic t_frames;
    sgpioEnable = 1'b1;
    for (int k = 0; k < 3; k++) begin
      wait_frame();
      cmp("frame word", w(k), {rx1, rx0});
    end
    cmp("ready after pop", 16'h0001, {15'h0000, statusReady});
  endtask

  task automatic t_abort;
    tick(3000);
    sgpioEnable = 1'b0;
    tick(20);
    sgpioEnable = 1'b1;
    wait_frame();
    cmp("frame word", w(4), {rx1, rx0});
  endtask

  initial begin
    srst = 1'b1;
    sgpioEnable = 1'b0;
    statusValid = 1'b0;
    statusData = 16'h0000;
    cmdActive = 8'h00;
    gpioDriveLow = 4'h0;
    closedSw = 8'h21;
    interlockEnable = 8'h28;
    comboFlexStrap = 16'h021F;
    comboPolarityStrap = 8'h02;
    tick(8);
    srst = 1'b0;
    tick(6);
    t_ports();
    t_led();
    t_gpio();
    t_fill();
    t_frames();
    t_abort();
    summarize();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end
endmodule
